/* File: core/relay_cmp_regs.svh */
`ifndef RELAY_CMP_REGS_SVH
`define RELAY_CMP_REGS_SVH

// number of relay channels and measured quantities
`define RELAY_NUM        2
`define QTY_NUM          4
`define QTY_SEL_W        3
// value width: signed measurement in fixed point
`define VALUE_W          24
// quantity select code that makes a relay follow device health
`define QTY_SEL_FAULT    3'h4
// reset values
`define RELAY_EN_RST     1'b0
`define RELAY_STATE_RST  1'b0

`endif

/* File: core/relay_cmp_pkg.sv */
package relay_cmp_pkg;

   // window sense decided from which setpoints are defined and their order
   typedef enum logic [4:0] {
      WIN_OFF       = 5'h01,
      WIN_ABOVE     = 5'h02,
      WIN_BELOW     = 5'h04,
      WIN_NORMAL    = 5'h08,
      WIN_INVERTED  = 5'h10
   } window_e;

endpackage

/* File: core/relay_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "relay_cmp_regs.svh"

module relay_channel (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic                       sample,
   input  wire logic                       meas_fail,
   input  wire logic                       health_ok,
   input  wire logic                       follow_fault,
   input  wire logic                       enable,
   input  wire logic                       above_set,
   input  wire logic                       below_set,
   input  wire logic signed [`VALUE_W-1:0] value,
   input  wire logic signed [`VALUE_W-1:0] above_sp,
   input  wire logic signed [`VALUE_W-1:0] below_sp,
   input  wire logic        [`VALUE_W-1:0] hyst,
   output logic                            active
);

   relay_cmp_pkg::window_e mode;
   logic                   active_r;
   logic                   active_nxt;
   logic signed [`VALUE_W+1:0] v;
   logic signed [`VALUE_W+1:0] a;
   logic signed [`VALUE_W+1:0] b;
   logic signed [`VALUE_W+1:0] h;
   logic                   hi_on;
   logic                   hi_off;
   logic                   lo_on;
   logic                   lo_off;

   // two extra bits so a setpoint plus or minus a full-scale hysteresis cannot wrap
   assign v = {{2{value[`VALUE_W-1]}}, value};
   assign a = {{2{above_sp[`VALUE_W-1]}}, above_sp};
   assign b = {{2{below_sp[`VALUE_W-1]}}, below_sp};
   assign h = $signed({2'b00, hyst});

   always_comb begin
      if (above_set && below_set) begin
         mode = (a > b) ? relay_cmp_pkg::WIN_NORMAL : relay_cmp_pkg::WIN_INVERTED;
      end else if (above_set) begin
         mode = relay_cmp_pkg::WIN_ABOVE;
      end else if (below_set) begin
         mode = relay_cmp_pkg::WIN_BELOW;
      end else begin
         mode = relay_cmp_pkg::WIN_OFF;
      end
   end

   // activation at the exact setpoint, release needs the hysteresis margin
   assign hi_on  = v >= a;
   assign hi_off = v < (a - h);
   assign lo_on  = v <= b;
   assign lo_off = v > (b + h);

   always_comb begin
      active_nxt = active_r;
      // the enable gates the health-following relay as well
      if (!enable) begin
         active_nxt = 1'b0;
      end else if (follow_fault) begin
         active_nxt = health_ok;
      end else if (meas_fail) begin
         active_nxt = 1'b0;
      end else if (sample) begin
         case (mode)
            relay_cmp_pkg::WIN_ABOVE: begin
               if (hi_on) active_nxt = 1'b1;
               else if (hi_off) active_nxt = 1'b0;
            end
            relay_cmp_pkg::WIN_BELOW: begin
               if (lo_on) active_nxt = 1'b1;
               else if (lo_off) active_nxt = 1'b0;
            end
            relay_cmp_pkg::WIN_NORMAL: begin
               // passive between setpoints, active beyond either
               if (hi_on || lo_on) active_nxt = 1'b1;
               else if (hi_off && lo_off) active_nxt = 1'b0;
            end
            relay_cmp_pkg::WIN_INVERTED: begin
               // above <= below: active inside the range, release at exact edge
               if (v > a && v < b) begin
                  if (v >= (a + h) && v <= (b - h)) active_nxt = 1'b1;
               end else begin
                  active_nxt = 1'b0;
               end
            end
            default: active_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_r <= `RELAY_STATE_RST;
      end else begin
         active_r <= active_nxt;
      end
   end

   assign active = active_r;

endmodule // relay_channel

`default_nettype wire

/* File: core/relay_setpoint_comparator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "relay_cmp_regs.svh"

module relay_setpoint_comparator (
   // clock and reset
   input  wire logic                                   CLK_SYS,
   input  wire logic                                   RESET_N,
   // measurements, one per quantity
   input  wire logic [`QTY_NUM*`VALUE_W-1:0]           MEAS_VALUE,
   input  wire logic [`QTY_NUM-1:0]                    MEAS_VALID,
   input  wire logic [`QTY_NUM-1:0]                    MEAS_FAIL,
   // device health, high in normal operation (pin, synchronised)
   input  wire logic                                   HEALTH_OK,
   // per-relay configuration
   input  wire logic [`RELAY_NUM*`QTY_SEL_W-1:0]       QTY_SEL,
   input  wire logic [`RELAY_NUM*`VALUE_W-1:0]         ABOVE_SP,
   input  wire logic [`RELAY_NUM*`VALUE_W-1:0]         BELOW_SP,
   input  wire logic [`RELAY_NUM-1:0]                  ABOVE_SET,
   input  wire logic [`RELAY_NUM-1:0]                  BELOW_SET,
   input  wire logic [`RELAY_NUM*`VALUE_W-1:0]         HYST,
   input  wire logic [`RELAY_NUM-1:0]                  ENABLE,
   // relay test
   input  wire logic                                   TEST_MODE,
   input  wire logic [`RELAY_NUM-1:0]                  TEST_STATE,
   // relay drive and status
   output logic      [`RELAY_NUM-1:0]                  RELAY_ACTIVE,
   output logic      [`RELAY_NUM-1:0]                  CMP_STATE
);

   logic              health_s1_r;
   logic              health_s2_r;
   logic [`RELAY_NUM-1:0] cmp_state;
   logic [`RELAY_NUM-1:0] relay_r;
   logic [`RELAY_NUM-1:0] relay_nxt;

   // health is a pin level, so it is synchronised before use
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         health_s1_r <= 1'b0;
         health_s2_r <= 1'b0;
      end else begin
         health_s1_r <= HEALTH_OK;
         health_s2_r <= health_s1_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `RELAY_NUM; g = g + 1) begin : g_relay
         logic [`QTY_SEL_W-1:0]       sel;
         logic                        follow_fault;
         logic                        sel_ok;
         logic [1:0]                  idx;
         logic signed [`VALUE_W-1:0]  val;
         logic                        smp;
         logic                        fail;

         assign sel          = QTY_SEL[g*`QTY_SEL_W +: `QTY_SEL_W];
         assign follow_fault = (sel == `QTY_SEL_FAULT);
         assign sel_ok       = (sel < `QTY_SEL_FAULT);
         assign idx          = sel[1:0];
         // any quantity can feed any relay independently
         assign val  = MEAS_VALUE[idx*`VALUE_W +: `VALUE_W];
         assign smp  = sel_ok & MEAS_VALID[idx];
         // an unknown select code is treated as a failed measurement
         assign fail = ~sel_ok | MEAS_FAIL[idx];

         relay_channel u_chan (
            .clk          (CLK_SYS),
            .reset_n      (RESET_N),
            .sample       (smp),
            .meas_fail    (fail),
            .health_ok    (health_s2_r),
            .follow_fault (follow_fault),
            .enable       (ENABLE[g]),
            .above_set    (ABOVE_SET[g]),
            .below_set    (BELOW_SET[g]),
            .value        (val),
            .above_sp     (ABOVE_SP[g*`VALUE_W +: `VALUE_W]),
            .below_sp     (BELOW_SP[g*`VALUE_W +: `VALUE_W]),
            .hyst         (HYST[g*`VALUE_W +: `VALUE_W]),
            .active       (cmp_state[g])
         );
      end
   endgenerate

   always_comb begin
      relay_nxt = cmp_state;
      if (TEST_MODE) begin
         relay_nxt = TEST_STATE;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         relay_r <= {`RELAY_NUM{`RELAY_STATE_RST}};
      end else begin
         relay_r <= relay_nxt;
      end
   end

   assign RELAY_ACTIVE = relay_r;
   assign CMP_STATE    = cmp_state;

endmodule // relay_setpoint_comparator

`default_nettype wire

/* File: tb/relay_contacts.sv */
`timescale 1ns/1ps
`default_nettype none
// alarm circuit view of the contacts: an unpowered coil always rests on C-NC
module relay_contacts (
   input  wire logic [1:0] active,
   output logic      [1:0] no_closed,
   output logic      [1:0] nc_closed
);
   assign no_closed = active;
   assign nc_closed = ~active;
endmodule // relay_contacts
`default_nettype wire

/* File: tb/relay_cmp_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_cmp_sva (
   input wire logic        CLK_SYS,
   input wire logic        RESET_N,
   input wire logic [95:0] MEAS_VALUE,
   input wire logic [3:0]  MEAS_VALID,
   input wire logic [3:0]  MEAS_FAIL,
   input wire logic        HEALTH_OK,
   input wire logic [5:0]  QTY_SEL,
   input wire logic [47:0] ABOVE_SP,
   input wire logic [47:0] BELOW_SP,
   input wire logic [1:0]  ABOVE_SET,
   input wire logic [1:0]  BELOW_SET,
   input wire logic [47:0] HYST,
   input wire logic [1:0]  ENABLE,
   input wire logic        TEST_MODE,
   input wire logic [1:0]  TEST_STATE,
   input wire logic [1:0]  RELAY_ACTIVE,
   input wire logic [1:0]  CMP_STATE
);
   // comparisons on relay 0, health on relay 1; one extra bit only, so a-h can wrap for a hysteresis above 2^23
   wire logic [1:0] q = QTY_SEL[1:0];
   wire logic ok = ENABLE[0] && QTY_SEL[2:0] < 3'h4 && !MEAS_FAIL[q];
   wire logic smp = ok && MEAS_VALID[q];
   wire logic signed [24:0] v = $signed(MEAS_VALUE[q*24+:24]);
   wire logic signed [24:0] a = $signed(ABOVE_SP[23:0]);
   wire logic signed [24:0] b = $signed(BELOW_SP[23:0]);
   wire logic signed [24:0] h = {1'b0, HYST[23:0]};
   wire logic one_a = ABOVE_SET[0] && !BELOW_SET[0];
   wire logic inv = ABOVE_SET[0] && BELOW_SET[0] && a <= b;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   a_relay_lag: assert property ($past(!TEST_MODE && RESET_N) |-> RELAY_ACTIVE[0] == $past(CMP_STATE[0]))
      else $error("relay 0 out of step with comparator");
   a_test_forces: assert property ($past(TEST_MODE && RESET_N) |-> RELAY_ACTIVE == $past(TEST_STATE))
      else $error("test state not applied");
   a_disabled_off: assert property (!ENABLE[0] |=> !CMP_STATE[0])
      else $error("disabled relay active");
   a_health_disabled: assert property (!ENABLE[1] |=> !CMP_STATE[1])
      else $error("disabled health relay active");
   a_fail_releases: assert property (ENABLE[0] && QTY_SEL[2:0] < 3'h4 && MEAS_FAIL[q] |=> !CMP_STATE[0])
      else $error("failed measurement kept relay");
   a_above_exact: assert property (smp && one_a && v >= a |=> CMP_STATE[0])
      else $error("no activation at setpoint");
   a_above_hyst: assert property (smp && one_a && v < a |=>
      CMP_STATE[0] == ($past(CMP_STATE[0]) && $past(v) >= $past(a - h))) else $error("hysteresis band wrong");
   a_inv_release: assert property (smp && inv && (v <= a || v >= b) |=> !CMP_STATE[0])
      else $error("inverted window kept relay");
   a_health_follow: assert property ((QTY_SEL[5:3] == 3'h4 && ENABLE[1] && !TEST_MODE && $stable(HEALTH_OK))[*6]
      |-> RELAY_ACTIVE[1] == HEALTH_OK) else $error("health relay wrong");
   c_above: cover property (smp && one_a);
   c_inv: cover property (smp && inv);
   c_test: cover property (TEST_MODE);
endmodule // relay_cmp_sva
bind relay_setpoint_comparator relay_cmp_sva u_relay_cmp_sva (.CLK_SYS, .RESET_N, .MEAS_VALUE, .MEAS_VALID,
   .MEAS_FAIL, .HEALTH_OK, .QTY_SEL, .ABOVE_SP, .BELOW_SP, .ABOVE_SET, .BELOW_SET, .HYST, .ENABLE, .TEST_MODE,
   .TEST_STATE, .RELAY_ACTIVE, .CMP_STATE);
`default_nettype wire

/* File: tb/relay_setpoint_comparator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_setpoint_comparator_tb;
   logic        CLK_SYS = 1'b0;
   logic        RESET_N = 1'b0;
   logic        HEALTH_OK = 1'b1;
   logic        TEST_MODE = 1'b0;
   logic [95:0] MEAS_VALUE = '0;
   logic [3:0]  MEAS_VALID = 4'h0, MEAS_FAIL = 4'h0;
   // relay 0 watches quantity 1, relay 1 follows device health
   logic [5:0]  QTY_SEL = 6'h21;
   logic [47:0] ABOVE_SP = '0, BELOW_SP = '0, HYST = '0;
   logic [1:0]  ABOVE_SET = 2'h0, BELOW_SET = 2'h0, ENABLE = 2'h0, TEST_STATE = 2'h0;
   logic [1:0]  RELAY_ACTIVE, CMP_STATE, no_c, nc_c;
   int          fails = 0, tests_run = 0;
   relay_setpoint_comparator u_relay_setpoint_comparator (.CLK_SYS, .RESET_N, .MEAS_VALUE, .MEAS_VALID,
      .MEAS_FAIL, .HEALTH_OK, .QTY_SEL, .ABOVE_SP, .BELOW_SP, .ABOVE_SET, .BELOW_SET, .HYST, .ENABLE,
      .TEST_MODE, .TEST_STATE, .RELAY_ACTIVE, .CMP_STATE);
   relay_contacts u_relay_contacts (.active(RELAY_ACTIVE), .no_closed(no_c), .nc_closed(nc_c));
   initial forever #10 CLK_SYS = ~CLK_SYS;
   task chk(input string n, input logic [1:0] e, input logic [1:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // one-cycle sample pulse, then judge the relay after its two-edge path
   task smp(input int q, input int v, input logic e);
      @(posedge CLK_SYS);
      MEAS_VALUE[q*24+:24] <= v[23:0];
      MEAS_VALID[q] <= 1'b1;
      @(posedge CLK_SYS);
      MEAS_VALID[q] <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      #1 chk("relay0", e, RELAY_ACTIVE[0]);
   endtask
   task cfg(input logic as, input int a, input logic bs, input int b, input int h);
      @(posedge CLK_SYS);
      ABOVE_SET[0] <= as;
      BELOW_SET[0] <= bs;
      ABOVE_SP[23:0] <= a[23:0];
      BELOW_SP[23:0] <= b[23:0];
      HYST[23:0] <= h[23:0];
   endtask
   task t_above;
      cfg(1'b1, 100, 1'b0, 0, 10);
      smp(1, 200, 1'b0);
      @(posedge CLK_SYS);
      ENABLE[0] <= 1'b1;
      smp(1, 99, 1'b0);
      smp(1, 100, 1'b1);
      smp(1, 90, 1'b1);
      smp(2, 0, 1'b1);
      smp(1, 89, 1'b0);
   endtask
   task t_below;
      cfg(1'b0, 0, 1'b1, 50, 10);
      smp(1, 51, 1'b0);
      smp(1, 50, 1'b1);
      smp(1, 61, 1'b0);
   endtask
   task t_windows;
      cfg(1'b1, 100, 1'b1, 50, 5);
      smp(1, 75, 1'b0);
      smp(1, 50, 1'b1);
      smp(1, 55, 1'b1);
      smp(1, 56, 1'b0);
      cfg(1'b1, 50, 1'b1, 100, 5);
      smp(1, 52, 1'b0);
      smp(1, 55, 1'b1);
      smp(1, 51, 1'b1);
      smp(1, 50, 1'b0);
      smp(1, 120, 1'b0);
   endtask
   task t_fail;
      smp(1, 70, 1'b1);
      @(posedge CLK_SYS);
      MEAS_FAIL[1] <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      #1 chk("failed", 1'b0, RELAY_ACTIVE[0]);
      @(posedge CLK_SYS);
      MEAS_FAIL[1] <= 1'b0;
   endtask
   task t_health;
      @(posedge CLK_SYS);
      #1 chk("rel1_off", 1'b0, RELAY_ACTIVE[1]);
      @(posedge CLK_SYS);
      ENABLE[1] <= 1'b1;
      repeat (8) @(posedge CLK_SYS);
      #1 chk("no1", 1'b1, no_c[1]);
      @(posedge CLK_SYS);
      HEALTH_OK <= 1'b0;
      repeat (8) @(posedge CLK_SYS);
      #1 chk("nc1", 1'b1, nc_c[1]);
      @(posedge CLK_SYS);
      HEALTH_OK <= 1'b1;
   endtask
   task t_test;
      @(posedge CLK_SYS);
      ENABLE[0] <= 1'b0;
      TEST_MODE <= 1'b1;
      TEST_STATE <= 2'h1;
      repeat (3) @(posedge CLK_SYS);
      #1 chk("test", 2'h1, RELAY_ACTIVE);
      chk("cmp_state", 2'h2, CMP_STATE);
      @(posedge CLK_SYS);
      TEST_MODE <= 1'b0;
   endtask
   task print_verdict;
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      t_above();
      t_below();
      t_windows();
      t_fail();
      t_health();
      t_test();
      print_verdict();
   end
   initial begin
      repeat (3000) @(posedge CLK_SYS);
      fails++;
      print_verdict();
   end
endmodule // relay_setpoint_comparator_tb
`default_nettype wire
